// >>> verilog/spi_byte_engine.sv
// spi_byte_engine: combined master/slave spi, one byte each way per transfer
// assumes software strobes (dataWr, dataRd, statusRd) are one-cycle pulses on clk_sys
// Functional notes
// R1: master starts clocking when a byte is ready
// R2: slave cpha 0: select active to inactive
// R3: slave cpha 1: first edge to last sample
// R4: data write loads shift register directly
// R5: completed byte copied to receive buffer
// R6: clock counter only matters in master mode
// R7: serial pins are push-pull only
// R8: slave drives miso only while selected
// R9: master data write launches the transfer
// R10: master sets done after last cycle
// R11: slave sets done after last sample
// R12: done clears on status read then data access
// R13: remote sck at most clk_sys over eight
// R14: completion with done set is overrun
// R15: write in busy window is collision
// R16: select while master: fault, release, slave
// R17: external logic keeps select high in master
// R18: select lost mid-transfer: discard and abort
// R19: software programs control before starting
// R20: cpol and cpha pick drive and sample edges
// R21: slave select is active low
// R22: one byte each way per transfer
// R23: reset clears flags, buffer and transfer
`timescale 1ns/1ps
`default_nettype none
module spi_byte_engine
  import spi_byte_pkg::*;
(
  input  wire logic    clk_sys,
  input  wire logic    rst,
  input  wire ctrl_t   ctrl,        // mode, polarity, phase
  input  wire logic [7:0] clkCount, // master sck period in clk_sys cycles
  input  wire logic    dataWr,      // data register write strobe
  input  wire logic [7:0] dataWrByte,
  input  wire logic    dataRd,      // data register read strobe
  input  wire logic    statusRd,    // status register read strobe
  output logic [7:0]   rxData,      // receive buffer
  output status_t      status,      // sticky flags
  input  wire logic    sckIn,
  output logic         sckOut,
  output logic         sckOe_n,
  input  wire logic    mosiIn,
  output logic         mosiOut,
  output logic         mosiOe_n,
  input  wire logic    misoIn,
  output logic         misoOut,
  output logic         misoOe_n,
  input  wire logic    ssel_n
);
  xfer_state_t state_ff, nxt_state;   // transfer sequencer
  logic [7:0]  shift_ff, nxt_shift;   // single shift register, no tx buffer
  logic [7:0]  rxBuf_ff;              // one-byte receive buffer
  logic [7:0]  halfCnt_ff;            // master half-period down counter
  logic [4:0]  edgeCnt_ff;            // sck edges seen this transfer
  logic [3:0]  sampleCnt_ff;          // bits sampled this transfer
  logic        sckLvl_ff;             // master sck level
  logic        txBit_ff;              // bit presented on mosi/miso
  logic        sckPrev_ff;            // last synced sck, for edge finding
  logic        faultLatch_ff;         // forced slave after a mode fault
  logic        wcolWindow_ff;         // writes collide while set
  logic        statusSeen_ff;         // status read while done was set
  logic        drvM_ff, drvS_ff;      // driver enables, active high inside
  status_t     flags_ff, nxt_flags;
  logic [SYNC_BITS-1:0] pinSync;      // synced sck, mosi, miso, ssel_n

  // pins come from another domain: two flops before any logic
  sync_2ff #(.WIDTH(SYNC_BITS)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .asyncIn ({sckIn, mosiIn, misoIn, ssel_n}),
    .syncOut (pinSync)
  );

  // decode of synced pins and mode
  wire sckS       = pinSync[3];
  wire mosiS      = pinSync[2];
  wire misoS      = pinSync[1];
  wire selActive  = ~pinSync[0];                          // R21
  wire isMaster   = ctrl.masterEn & ~faultLatch_ff;
  wire modeFault  = isMaster & selActive;                 // R16
  wire inMaster   = (state_ff == ST_MASTER);
  wire inSlave    = (state_ff == ST_SLAVE);

  // master sck timing; the counter value is ignored in slave mode
  wire [7:0] halfReq  = {1'b0, clkCount[7:1]};
  wire [7:0] halfLoad = (halfReq < MIN_HALF) ? MIN_HALF : halfReq; // R6
  wire mEdge  = inMaster & (halfCnt_ff == 8'h00);
  wire mLead  = mEdge & ~edgeCnt_ff[0];
  // slave edges found from the synced remote clock
  wire sEdge  = inSlave & (sckS != sckPrev_ff);
  wire sLead  = sEdge & (sckS != ctrl.cpol);
  wire edgeEv = mEdge | sEdge;
  wire leadEv = mLead | sLead;
  // cpha 0 samples leading edges, cpha 1 trailing edges
  wire sampleEv = edgeEv & (leadEv != ctrl.cpha);         // R20
  wire driveEv  = edgeEv & ~sampleEv;                     // R20
  wire inBit    = inMaster ? misoS : mosiS;
  wire [7:0] rxNew = {shift_ff[6:0], inBit};

  // completion, abort and software access decode
  wire lastSample = sampleEv & (sampleCnt_ff == LAST_SAMPLE);
  wire masterDone = mEdge & (edgeCnt_ff == LAST_EDGE) & ~modeFault; // R10
  wire slaveDone  = inSlave & lastSample & selActive;     // R11
  wire complete   = masterDone | slaveDone;
  // a completion that falls on a sampling edge must take the last bit as well
  wire [7:0] doneByte = sampleEv ? rxNew : shift_ff;
  wire started    = ~ctrl.cpha | (edgeCnt_ff != 5'h00);
  wire abortEv    = inSlave & ~selActive & started;       // R18
  wire wrOk       = dataWr & (state_ff == ST_IDLE) & ~wcolWindow_ff; // R4
  wire wrColl     = dataWr & ~wrOk;                       // R15
  wire startM     = wrOk & isMaster & ~modeFault;         // R9
  wire startS     = (state_ff == ST_IDLE) & ~isMaster & selActive;
  wire dataAcc    = (dataRd | dataWr) & statusSeen_ff;    // R12
  wire storeRx    = complete & ~flags_ff.xferDoneFlag;    // R5
  wire overrun    = complete & flags_ff.xferDoneFlag;     // R14

  // next state of the sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (startM) nxt_state = ST_MASTER;
        else if (startS) nxt_state = ST_SLAVE;           // R2
      end
      ST_MASTER: begin
        if (modeFault || masterDone) nxt_state = ST_IDLE; // R16
      end
      ST_SLAVE: begin
        // cpha 0 keeps the frame until select drops
        if (!selActive) nxt_state = ST_IDLE;
        else if (slaveDone) nxt_state = ctrl.cpha ? ST_IDLE : ST_SLV_HOLD; // R3
      end
      ST_SLV_HOLD: begin
        if (!selActive) nxt_state = ST_IDLE;             // R2
      end
    endcase
  end

  // next shift register value: write, sample or discard
  always_comb begin
    nxt_shift = shift_ff;
    if (abortEv) nxt_shift = RST_BYTE;                   // R18
    else if (wrOk) nxt_shift = dataWrByte;               // R4
    else if (sampleEv) nxt_shift = rxNew;                // R22
  end

  // next flags: a hardware set always beats a software clear
  always_comb begin
    nxt_flags = flags_ff;
    nxt_flags.xferDoneFlag = complete | (flags_ff.xferDoneFlag & ~dataAcc); // R10
    nxt_flags.readOverrunFlag = overrun | (flags_ff.readOverrunFlag & ~statusRd);
    nxt_flags.writeCollisionFlag = wrColl | (flags_ff.writeCollisionFlag & ~statusRd);
    nxt_flags.modeFaultFlag = modeFault | (flags_ff.modeFaultFlag & ~statusRd);
    nxt_flags.slaveAbortFlag = abortEv | (flags_ff.slaveAbortFlag & ~statusRd);
  end

  // sequencer, data path and flags
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin                                       // R23
      state_ff <= ST_IDLE;
      shift_ff <= RST_BYTE;
      rxBuf_ff <= RST_BYTE;
      flags_ff <= RST_STATUS;
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      flags_ff <= nxt_flags;
      if (storeRx) rxBuf_ff <= doneByte;                 // R5
    end
  end

  // bit and edge counters, cleared between transfers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      edgeCnt_ff   <= 5'h00;
      sampleCnt_ff <= 4'h0;
    end else if (nxt_state == ST_IDLE || startM || startS) begin
      edgeCnt_ff   <= 5'h00;
      sampleCnt_ff <= 4'h0;
    end else begin
      edgeCnt_ff   <= edgeCnt_ff + {4'h0, edgeEv};
      sampleCnt_ff <= sampleCnt_ff + {3'h0, sampleEv};
    end
  end

  // master clock generator; idle level follows cpol
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      halfCnt_ff <= MIN_HALF;
      sckLvl_ff  <= 1'b0;
    end else if (!inMaster || startM) begin
      halfCnt_ff <= halfLoad - 8'h01;
      sckLvl_ff  <= ctrl.cpol;
    end else if (mEdge) begin
      halfCnt_ff <= halfLoad - 8'h01;
      sckLvl_ff  <= ~sckLvl_ff;                          // R1
    end else begin
      halfCnt_ff <= halfCnt_ff - 8'h01;
    end
  end

  // presented bit: byte msb at load (cpha 0 needs it before the first edge)
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) txBit_ff <= 1'b0;
    else if (abortEv) txBit_ff <= 1'b0;
    else if (wrOk) txBit_ff <= dataWrByte[7];            // R20
    else if (driveEv) txBit_ff <= shift_ff[7];           // R20
  end

  // software handshake state and mode-fault latch
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sckPrev_ff    <= 1'b1;  // matches the synchroniser reset, no false edge
      faultLatch_ff <= 1'b0;
      wcolWindow_ff <= 1'b0;
      statusSeen_ff <= 1'b0;
    end else begin
      sckPrev_ff    <= sckS;
      // stays slave until software drops masterEn
      faultLatch_ff <= modeFault | (faultLatch_ff & ctrl.masterEn); // R16
      // an aborted frame never completes, so it closes the window itself
      wcolWindow_ff <= (startM | startS
                     | (wcolWindow_ff & ~(statusRd & flags_ff.xferDoneFlag))) & ~abortEv; // R15
      statusSeen_ff <= (statusRd & flags_ff.xferDoneFlag) | (statusSeen_ff & ~dataAcc); // R12
    end
  end

  // push-pull drivers; open-drain is not offered
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      drvM_ff <= 1'b0;
      drvS_ff <= 1'b0;
    end else begin
      drvM_ff <= isMaster & ~modeFault;                  // R16
      drvS_ff <= ~ctrl.masterEn & selActive | faultLatch_ff & selActive; // R8
    end
  end

  // outputs straight from flops
  assign sckOut   = sckLvl_ff;                           // R7
  assign mosiOut  = txBit_ff;
  assign misoOut  = txBit_ff;
  assign sckOe_n  = ~drvM_ff;
  assign mosiOe_n = ~drvM_ff;
  assign misoOe_n = ~drvS_ff;                            // R8
  assign rxData   = rxBuf_ff;
  assign status   = flags_ff;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_done_sets: assert property (complete |=> status.xferDoneFlag) // R10
    else $error("done flag not set after completion");
  a_rx_store: assert property (storeRx |=> rxData == $past(doneByte)) // R5
    else $error("receive buffer missed completed byte");
  a_overrun_keep: assert property (overrun |=> $stable(rxData) && status.readOverrunFlag) // R14
    else $error("overrun overwrote buffer or lost flag");
  a_write_collision_flag_drop: assert property (wrColl && !sampleEv && !abortEv
                                |=> status.writeCollisionFlag && shift_ff == $past(shift_ff)) // R15
    else $error("collided write not flagged");
  a_fault_release: assert property (modeFault |=> status.modeFaultFlag && sckOe_n && mosiOe_n
                                    && state_ff != ST_MASTER ##1 !isMaster) // R16
    else $error("mode fault did not release drivers");
  a_abort_discard: assert property (abortEv |=> status.slaveAbortFlag && shift_ff == RST_BYTE
                                    && state_ff == ST_IDLE) // R18
    else $error("slave abort not handled");
  a_miso_sel: assert property (!misoOe_n |-> $past(selActive)) // R8
    else $error("miso driven while not selected");
  a_done_clear: assert property (status.xferDoneFlag && dataAcc && !complete |=> !status.xferDoneFlag) // R12
    else $error("done flag did not clear");
  a_done_hold: assert property (status.xferDoneFlag && !statusSeen_ff && !complete
                                |=> status.xferDoneFlag) // R12
    else $error("done flag cleared without status read");
  a_write_launch: assert property (startM |=> state_ff == ST_MASTER ##1 sckOut == ctrl.cpol) // R9
    else $error("master write did not launch");
  a_sck_half: assert property (inMaster && $changed(sckOut) |=> $stable(sckOut)[*3]) // R6
    else $error("master sck faster than clk_sys over eight");

  c_master_xfer: cover property (masterDone);
  c_slave_xfer:  cover property (slaveDone);
  c_slave_abort: cover property (abortEv);
  c_overrun:     cover property (overrun);
endmodule : spi_byte_engine
`default_nettype wire

// >>> common/spi_byte_pkg.sv
// spi_byte_pkg: shared types and constants of the spi byte engine
// assumes the engine runs on clk_sys and all control bits arrive as plain ports
package spi_byte_pkg;
  // control bits steering the engine, held by software
  typedef struct packed {
    logic masterEn;  // 1: master, 0: slave
    logic cpol;      // idle level of the serial clock
    logic cpha;      // 0: sample leading edge, 1: sample trailing edge
  } ctrl_t;

  // sticky status flags shown to software
  typedef struct packed {
    logic xferDoneFlag;
    logic readOverrunFlag;
    logic writeCollisionFlag;
    logic modeFaultFlag;
    logic slaveAbortFlag;
  } status_t;

  // transfer sequencing states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MASTER,
    ST_SLAVE,
    ST_SLV_HOLD
  } xfer_state_t;

  localparam logic [3:0] LAST_SAMPLE = 4'h7;   // index of the eighth sample
  localparam logic [4:0] LAST_EDGE   = 5'h0F;  // index of the sixteenth clock edge
  localparam logic [7:0] MIN_HALF    = 8'h04;  // half period floor, sck <= clk_sys/8
  localparam logic [7:0] RST_BYTE    = 8'h00;  // shift register and buffer after reset
  localparam status_t    RST_STATUS  = '0;     // all flags clear after reset
  localparam int         SYNC_BITS   = 4;      // sck, mosi, miso, ssel
endpackage : spi_byte_pkg

// >>> verilog/sync_2ff.sv
// sync_2ff: two flip-flop synchroniser for a group of asynchronous levels
// assumes inputs are slow levels; the first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  // one independent two-stage chain per bit
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic stage1_ff;  // metastability catcher, read only by stage two
    logic stage2_ff;  // settled copy
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        stage1_ff <= 1'b1;
        stage2_ff <= 1'b1;
      end else begin
        stage1_ff <= asyncIn[i];
        stage2_ff <= stage1_ff;
      end
    end
    assign syncOut[i] = stage2_ff;
  end
endmodule : sync_2ff
`default_nettype wire

// >>> dv/spi_far_model.sv
// spi_far_model: remote spi party, slave while the engine masters, master otherwise
// assumes the bench resolves each line from the engine's output enables
`timescale 1ns/1ps
`default_nettype none
module spi_far_model
  import spi_byte_pkg::*;
(
  input  wire logic cpol,
  input  wire logic cpha,
  input  wire logic farSel,    // high: we act as the selected slave
  input  wire logic sckLine,
  input  wire logic mosiLine,
  input  wire logic misoLine,
  output logic      farSck,
  output logic      farMosi,
  output logic      farMiso,
  output logic      farSsel_n
);
  logic [7:0] sh;      // bits still to send
  logic [7:0] rx;      // bits seen from the engine
  logic       outBit;  // slave bit on miso
  logic       mBit;    // master bit on mosi
  logic       sckV;    // master clock level inside a frame
  logic       busy;    // master frame running
  logic       alt;     // released lines toggle so stale values never pass
  initial begin
    farSsel_n = 1'b1;
    {sh, rx, outBit, mBit, sckV, busy, alt} = '0;
  end
  always #30 alt = ~alt;
  // clock stands still at idle level between frames
  assign farSck  = busy ? sckV : cpol;
  assign farMosi = busy ? mBit : alt;
  assign farMiso = farSel ? outBit : alt;
  // slave role: leading edge drives (cpha 1) or samples (cpha 0)
  always @(sckLine) begin
    if (farSel) begin
      if (sckLine != cpol) begin
        if (cpha) begin
          outBit = sh[7];
          sh = sh << 1;
        end else rx = {rx[6:0], mosiLine};
      end else if (cpha) rx = {rx[6:0], mosiLine};
      else begin
        sh = sh << 1;
        outBit = sh[7];
      end
    end
  end
  task load(input logic [7:0] b);
    sh = b;
    rx = '0;
    outBit = b[7];
  endtask : load
  // master role: 160 ns period keeps sck at or below clk_sys over eight
  task xfer(input logic [7:0] b, input int nb);
    sh = b;
    rx = '0;
    sckV = cpol;
    busy = 1'b1;
    farSsel_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      if (!cpha) mBit = sh[7];
      #80;
      sckV = ~cpol;
      if (cpha) mBit = sh[7];
      else rx = {rx[6:0], misoLine};
      #80;
      sckV = cpol;
      if (cpha) rx = {rx[6:0], misoLine};
      sh = sh << 1;
    end
    #80;
    farSsel_n = 1'b1;
    busy = 1'b0;
  endtask : xfer
endmodule : spi_far_model
`default_nettype wire

// >>> dv/tb.sv
// tb: self-checking bench of the spi byte engine against a remote party model
// assumes single clk_sys domain; pins resolved here from enables
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  import spi_byte_pkg::*;
  logic       clk_sys, rst, dataWr, dataRd, statusRd;
  ctrl_t      ctrl;
  logic [7:0] clkCount, dataWrByte, rxData, tx, d;
  status_t    status;
  logic       sckOut, sckOe_n, mosiOut, mosiOe_n, misoOut, misoOe_n, lastDone;
  wire logic  farSck, farMosi, farMiso, farSsel_n;
  int         num_errors, n_checks, seed;
  logic [7:0] expQ[$];  // rx bytes expected at each done rise
  logic [7:0] expB;     // oldest expectation, popped once per compare
  // each line follows whoever enables onto it
  wire logic  sckLine  = sckOe_n ? farSck : sckOut;
  wire logic  mosiLine = mosiOe_n ? farMosi : mosiOut;
  wire logic  misoLine = misoOe_n ? farMiso : misoOut;
  spi_byte_engine DUT (.clk_sys(clk_sys), .rst(rst), .ctrl(ctrl), .clkCount(clkCount), .dataWr(dataWr),
    .dataWrByte(dataWrByte), .dataRd(dataRd), .statusRd(statusRd), .rxData(rxData), .status(status),
    .sckIn(sckLine), .sckOut(sckOut), .sckOe_n(sckOe_n), .mosiIn(mosiLine), .mosiOut(mosiOut),
    .mosiOe_n(mosiOe_n), .misoIn(misoLine), .misoOut(misoOut), .misoOe_n(misoOe_n), .ssel_n(farSsel_n));
  spi_far_model far (.cpol(ctrl.cpol), .cpha(ctrl.cpha), .farSel(ctrl.masterEn), .sckLine(sckLine),
    .mosiLine(mosiLine), .misoLine(misoLine), .farSck(farSck), .farMosi(farMosi), .farMiso(farMiso),
    .farSsel_n(farSsel_n));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // one software access: strobes high for exactly one edge
  task sw(input logic w, input logic r, input logic s, input logic [7:0] b);
    @(posedge clk_sys);
    {dataWr, dataRd, statusRd} <= {w, r, s};
    dataWrByte <= b;
    @(posedge clk_sys);
    {dataWr, dataRd, statusRd} <= 3'h0;
  endtask : sw
  task wait_done();
    for (int i = 0; i < 3000 && status.xferDoneFlag !== 1'b1; i++) @(posedge clk_sys);
  endtask : wait_done
  task report_and_stop();
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // monitor: each rise of done takes the oldest expected byte
  always @(negedge clk_sys) begin
    if (status.xferDoneFlag === 1'b1 && lastDone === 1'b0 && expQ.size() > 0) begin
      expB = expQ.pop_front();
      `CHK(rxData, expB)
    end
    lastDone = status.xferDoneFlag;
  end
  initial begin
    #1_000_000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    {rst, dataWr, dataRd, statusRd, lastDone} = 5'h10;
    {ctrl, clkCount, dataWrByte, num_errors, n_checks} = '0;
    seed = 93717;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    `CHK(status, RST_STATUS)
    `CHK(rxData, RST_BYTE)
    // master in all four clock modes; control set before each start
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys);
      ctrl <= '{1'b1, m[1], m[0]};
      clkCount <= 8'h08 + 8'(m * 4);
      repeat (4) @(posedge clk_sys);
      tx = $random(seed);
      d = $random(seed);
      far.load(tx);
      expQ.push_back(tx);
      sw(1'b1, 1'b0, 1'b0, d);
      `CHK(sckOe_n, 1'b0)
      if (m == 0) sw(1'b1, 1'b0, 1'b0, ~d);
      wait_done();
      repeat (2) @(posedge clk_sys);
      `CHK(far.rx, d)
      `CHK(status.writeCollisionFlag, m == 0)
      sw(1'b0, 1'b1, 1'b0, 8'h00);
      `CHK(status.xferDoneFlag, 1'b1)
      sw(1'b0, 1'b0, 1'b1, 8'h00);
      sw(1'b0, 1'b1, 1'b0, 8'h00);
      @(negedge clk_sys);
      `CHK(status.xferDoneFlag, 1'b0)
    end
    // slave: transfer, overrun without clearing, then abort
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_sys);
      ctrl <= '{1'b0, 1'b0, m[0]};
      repeat (4) @(posedge clk_sys);
      `CHK(misoOe_n, 1'b1)
      d = $random(seed);
      tx = $random(seed);
      sw(1'b1, 1'b0, 1'b0, d);
      expQ.push_back(tx);
      fork
        far.xfer(tx, 8);
        begin
          #400;
          `CHK(misoOe_n, 1'b0)
        end
      join
      repeat (6) @(posedge clk_sys);
      `CHK(far.rx, d)
      `CHK(status.xferDoneFlag, 1'b1)
      far.xfer(~tx, 8);
      repeat (6) @(posedge clk_sys);
      `CHK(status.readOverrunFlag, 1'b1)
      `CHK(rxData, tx)
      sw(1'b0, 1'b0, 1'b1, 8'h00);
      sw(1'b0, 1'b1, 1'b0, 8'h00);
      far.xfer(tx, 3);
      repeat (6) @(posedge clk_sys);
      `CHK(status.slaveAbortFlag, 1'b1)
      `CHK(status.xferDoneFlag, 1'b0)
      sw(1'b0, 1'b0, 1'b1, 8'h00);
    end
    // select driven low while master
    @(posedge clk_sys);
    ctrl <= '{1'b1, 1'b0, 1'b0};
    repeat (4) @(posedge clk_sys);
    force_sel();
    `CHK(status.modeFaultFlag, 1'b1)
    `CHK({sckOe_n, mosiOe_n}, 2'h3)
    report_and_stop();
  end
  task force_sel();
    far.farSsel_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : force_sel
endmodule : tb
`default_nettype wire
